// [ufs_core.sv]
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module ufs_core (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Register port.
  input wire ufs_pkg::ufs_bus_t bus,
  output logic [31:0] rdata,
  // Serial line and modem lines.
  input wire logic serial_rx_in,
  output logic serial_tx_out,
  input wire ufs_pkg::ufs_modem_t modem,
  output logic request_to_send_out_n,
  output logic terminal_ready_out_n,
  // Interrupt, DMA and low-power reference.
  output logic irq,
  output logic tx_dma_req,
  output logic rx_dma_req,
  output logic lowpower_tick
);
  import ufs_pkg::*;

  logic [15:0] integer_divisor_reg;
  logic [5:0] fraction_divisor_reg;
  logic [6:0] line_control_reg;
  logic [6:0] ctrl_q;
  logic [2:0] ifls_q;
  logic [4:0] imsc_q, ris_q;
  logic [7:0] ilpr_q, lp_cnt_q;
  logic [15:0] bcnt_q;
  logic [5:0] facc_q;
  logic carry_q, oversample_tick;
  logic [7:0] tx_mem [DEPTH];
  logic [11:0] rx_mem [DEPTH];
  logic [3:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic [4:0] tx_cnt_q, rx_cnt_q, cap, lvl;
  logic tx_push, tx_pop, rx_push, rx_pop, rx_done, tx_trig, rx_trig, busy;
  ufs_state_t tx_st_q, rx_st_q;
  logic [3:0] tx_sub_q, rx_sub_q;
  logic [2:0] tx_bit_q, rx_bit_q;
  logic [7:0] tx_sh_q, rx_sh_q;
  logic tx_stp_q, tx_line_q, rx_par_q, rx_pe_q, rx_fe_q, rx_be_q, ovr_q;
  logic [9:0] tmo_q;
  ufs_modem_t modem_q;
  logic [31:0] rd_mux;
  logic wr_data, rd_data;
  logic [2:0] last_bit;
  logic [6:0] fsum;

  // Word length, buffer capacity and trigger level.
  assign last_bit = {1'b0, line_control_reg[LCR_WLEN +: 2]} + 3'h4;
  assign cap = line_control_reg[LCR_FEN] ? CAP_ON : CAP_OFF;
  assign lvl = line_control_reg[LCR_FEN] ?
    TRIG_LVL[ifls_q > 3'h4 ? 3'h4 : ifls_q] : CAP_OFF;
  assign tx_trig = tx_cnt_q < lvl;
  assign rx_trig = rx_cnt_q >= lvl;
  assign wr_data = bus.wr && bus.addr == OFS_DATA;
  assign rd_data = bus.rd && bus.addr == OFS_DATA;
  assign tx_push = wr_data && tx_cnt_q < cap;
  assign rx_pop = rd_data && rx_cnt_q != 5'h00;
  assign rx_push = rx_done && rx_cnt_q < cap;
  assign busy = tx_cnt_q != 5'h00 || tx_st_q != ST_IDLE;
  assign fsum = {1'b0, facc_q} + {1'b0, fraction_divisor_reg};

  // Software registers; control and line settings steer the engines.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      integer_divisor_reg <= IBRD_RST;
      fraction_divisor_reg <= FBRD_RST;
      line_control_reg <= LCR_RST;
      ctrl_q <= CR_RST;
      ifls_q <= IFLS_RST;
      imsc_q <= 5'h00;
      ilpr_q <= LP_DIV_RST;
    end else if (bus.wr) begin
      case (bus.addr)
        OFS_IBRD: integer_divisor_reg <= bus.wdata[15:0];
        OFS_FBRD: fraction_divisor_reg <= bus.wdata[5:0];
        OFS_LCR: line_control_reg <= bus.wdata[6:0];
        OFS_CR: ctrl_q <= bus.wdata[6:0];
        OFS_IFLS: ifls_q <= bus.wdata[2:0];
        OFS_IMSC: imsc_q <= bus.wdata[4:0];
        OFS_ILPR: ilpr_q <= bus.wdata[7:0];
        default: ;
      endcase
    end
  end

  // Fractional divider: the period stretches by one cycle on each fraction carry.
  always_ff @(posedge core_clk) begin
    if (srst || integer_divisor_reg == 16'h0000) begin
      bcnt_q <= 16'h0000;
      facc_q <= 6'h00;
      carry_q <= 1'b0;
      oversample_tick <= 1'b0;
    end else if (bcnt_q + 16'h0001 >= integer_divisor_reg + {15'h0000, carry_q}) begin
      bcnt_q <= 16'h0000;
      facc_q <= fsum[5:0];
      carry_q <= fsum[6];
      oversample_tick <= 1'b1;
    end else begin
      bcnt_q <= bcnt_q + 16'h0001;
      oversample_tick <= 1'b0;
    end
  end

  // Low-power reference divides the core clock down to about 1.8432 MHz.
  always_ff @(posedge core_clk) begin
    if (srst || lp_cnt_q + 8'h01 >= ilpr_q) begin
      lp_cnt_q <= 8'h00;
      lowpower_tick <= !srst;
    end else begin
      lp_cnt_q <= lp_cnt_q + 8'h01;
      lowpower_tick <= 1'b0;
    end
  end

  // Transmit buffer.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_wp_q <= 4'h0;
      tx_rp_q <= 4'h0;
      tx_cnt_q <= 5'h00;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp_q] <= bus.wdata[7:0];
        tx_wp_q <= tx_wp_q + 4'h1;
      end
      if (tx_pop) tx_rp_q <= tx_rp_q + 4'h1;
      tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
    end
  end

  // Transmitter starts a frame on a tick when enabled and allowed by CTS.
  assign tx_pop = tx_st_q == ST_IDLE && oversample_tick && tx_cnt_q != 5'h00 &&
    ctrl_q[CR_EN] && ctrl_q[CR_TXE] && !(ctrl_q[CR_CTSEN] && modem_q.cts_n);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_st_q <= ST_IDLE;
      tx_sub_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_sh_q <= 8'h00;
      tx_stp_q <= 1'b0;
      tx_line_q <= 1'b1;
    end else if (tx_pop) begin
      tx_st_q <= ST_START;
      tx_sh_q <= tx_mem[tx_rp_q];
      tx_sub_q <= 4'h0;
      tx_line_q <= 1'b0;
    end else if (oversample_tick && tx_st_q != ST_IDLE) begin
      tx_sub_q <= tx_sub_q + 4'h1;
      if (tx_sub_q == LAST_TICK) begin
        case (tx_st_q)
          ST_START: begin
            tx_st_q <= ST_DATA;
            tx_bit_q <= 3'h0;
            tx_line_q <= tx_sh_q[0];
          end
          ST_DATA: begin
            tx_bit_q <= tx_bit_q + 3'h1;
            if (tx_bit_q != last_bit) begin
              tx_line_q <= tx_sh_q[tx_bit_q + 3'h1];
            end else if (line_control_reg[LCR_PEN]) begin
              tx_st_q <= ST_PAR;
              tx_line_q <= ^(tx_sh_q & (8'hff >> (3'h7 - last_bit))) ^ !line_control_reg[LCR_EPS];
            end else begin
              tx_st_q <= ST_STOP;
              tx_stp_q <= line_control_reg[LCR_STP2];
              tx_line_q <= 1'b1;
            end
          end
          ST_PAR: begin
            tx_st_q <= ST_STOP;
            tx_stp_q <= line_control_reg[LCR_STP2];
            tx_line_q <= 1'b1;
          end
          ST_STOP: begin
            tx_stp_q <= 1'b0;
            if (!tx_stp_q) tx_st_q <= ST_IDLE;
          end
          default: tx_st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Receiver validates the start bit mid-bit, then samples every sixteen ticks.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_st_q <= ST_IDLE;
      rx_sub_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      {rx_par_q, rx_pe_q, rx_fe_q, rx_be_q, rx_done} <= 5'h00;
    end else begin
      rx_done <= 1'b0;
      case (rx_st_q)
        ST_IDLE: if (!serial_rx_in && ctrl_q[CR_EN] && ctrl_q[CR_RXE]) begin
          rx_st_q <= ST_START;
          rx_sub_q <= 4'h0;
          rx_sh_q <= 8'h00;
          {rx_par_q, rx_pe_q} <= 2'h0;
        end
        ST_START: if (oversample_tick) begin
          rx_sub_q <= rx_sub_q + 4'h1;
          if (rx_sub_q == MID_TICK) begin
            rx_st_q <= serial_rx_in ? ST_IDLE : ST_DATA;
            rx_sub_q <= 4'h0;
            rx_bit_q <= 3'h0;
          end
        end
        ST_DATA, ST_PAR, ST_STOP: if (oversample_tick) begin
          rx_sub_q <= rx_sub_q + 4'h1;
          if (rx_sub_q == LAST_TICK) begin
            if (rx_st_q == ST_DATA) begin
              rx_sh_q[rx_bit_q] <= serial_rx_in;
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == last_bit) begin
                rx_st_q <= line_control_reg[LCR_PEN] ? ST_PAR : ST_STOP;
              end
            end else if (rx_st_q == ST_PAR) begin
              rx_par_q <= serial_rx_in;
              rx_pe_q <= (^rx_sh_q ^ serial_rx_in) == line_control_reg[LCR_EPS];
              rx_st_q <= ST_STOP;
            end else begin
              rx_fe_q <= !serial_rx_in;
              rx_be_q <= !serial_rx_in && rx_sh_q == 8'h00 && !rx_par_q;
              rx_done <= 1'b1;
              rx_st_q <= ST_IDLE;
            end
          end
        end
        default: rx_st_q <= ST_IDLE;
      endcase
    end
  end

  // Receive buffer; a full buffer refuses the new character and raises overrun.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_wp_q <= 4'h0;
      rx_rp_q <= 4'h0;
      rx_cnt_q <= 5'h00;
      ovr_q <= 1'b0;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wp_q] <= {ovr_q, rx_be_q, rx_pe_q, rx_fe_q, rx_sh_q};
        rx_wp_q <= rx_wp_q + 4'h1;
      end
      if (rx_pop) rx_rp_q <= rx_rp_q + 4'h1;
      rx_cnt_q <= rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
      if (rx_done && !rx_push) ovr_q <= 1'b1;
      else if (rx_push) ovr_q <= 1'b0;
    end
  end

  // Receive timeout after 32 idle bit times with data still held.
  always_ff @(posedge core_clk) begin
    if (srst || rx_push || rx_pop || rx_cnt_q == 5'h00 || rx_st_q != ST_IDLE) begin
      tmo_q <= 10'h000;
    end else if (oversample_tick && tmo_q != RX_TMO_TICKS) begin
      tmo_q <= tmo_q + 10'h001;
    end
  end

  // Sticky sources; a set in the same cycle as a clear wins.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ris_q <= 5'h00;
      modem_q <= 4'hf;
    end else begin
      modem_q <= modem;
      ris_q[IRQ_RX] <= (ris_q[IRQ_RX] && !(bus.wr && bus.addr == OFS_ICR && bus.wdata[IRQ_RX]))
        || rx_trig;
      ris_q[IRQ_RT] <= (ris_q[IRQ_RT] && !(bus.wr && bus.addr == OFS_ICR && bus.wdata[IRQ_RT]))
        || (oversample_tick && tmo_q + 10'h001 == RX_TMO_TICKS);
      ris_q[IRQ_TX] <= (ris_q[IRQ_TX] && !(bus.wr && bus.addr == OFS_ICR && bus.wdata[IRQ_TX]))
        || tx_trig;
      ris_q[IRQ_MS] <= (ris_q[IRQ_MS] && !(bus.wr && bus.addr == OFS_ICR && bus.wdata[IRQ_MS]))
        || modem != modem_q;
      ris_q[IRQ_ERR] <= (ris_q[IRQ_ERR] && !(bus.wr && bus.addr == OFS_ICR && bus.wdata[IRQ_ERR]))
        || (rx_done && (rx_fe_q || rx_pe_q || rx_be_q || !rx_push));
    end
  end

  // Registered outputs to the pins, interrupt and DMA controller.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      serial_tx_out <= 1'b1;
      request_to_send_out_n <= 1'b1;
      terminal_ready_out_n <= 1'b1;
      irq <= 1'b0;
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
    end else begin
      serial_tx_out <= tx_line_q && !line_control_reg[LCR_BRK];
      request_to_send_out_n <= ctrl_q[CR_RTSEN] ? rx_trig : !ctrl_q[CR_RTS];
      terminal_ready_out_n <= !ctrl_q[CR_DTR];
      irq <= |(ris_q & imsc_q);
      tx_dma_req <= tx_trig && ctrl_q[CR_EN];
      rx_dma_req <= (rx_trig || rx_cnt_q != 5'h00) && ctrl_q[CR_EN];
    end
  end

  // Read mux; the data register pops one entry, unmapped offsets read zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (bus.addr)
      OFS_DATA: rd_mux = rx_cnt_q != 5'h00 ? {20'h00000, rx_mem[rx_rp_q]} : 32'h0000_0000;
      OFS_STAT: rd_mux = {20'h00000, modem_q, ovr_q, busy, rx_cnt_q == 5'h00,
        tx_cnt_q >= cap, rx_cnt_q >= cap, tx_cnt_q == 5'h00, rx_trig, tx_trig};
      OFS_IBRD: rd_mux = {16'h0000, integer_divisor_reg};
      OFS_FBRD: rd_mux = {26'h0000000, fraction_divisor_reg};
      OFS_LCR: rd_mux = {25'h0000000, line_control_reg};
      OFS_CR: rd_mux = {25'h0000000, ctrl_q};
      OFS_IFLS: rd_mux = {29'h00000000, ifls_q};
      OFS_IMSC: rd_mux = {27'h0000000, imsc_q};
      OFS_RIS: rd_mux = {27'h0000000, ris_q};
      OFS_ILPR: rd_mux = {24'h000000, ilpr_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) rdata <= 32'h0000_0000;
    else if (bus.rd) rdata <= rd_mux;
    else rdata <= 32'h0000_0000;
  end
endmodule

// [ufs_pkg.sv]
package ufs_pkg;
  // Register offsets, byte addresses on the plain register port.
  localparam logic [5:0] OFS_DATA = 6'h00;
  localparam logic [5:0] OFS_STAT = 6'h04;
  localparam logic [5:0] OFS_IBRD = 6'h08;
  localparam logic [5:0] OFS_FBRD = 6'h0c;
  localparam logic [5:0] OFS_LCR = 6'h10;
  localparam logic [5:0] OFS_CR = 6'h14;
  localparam logic [5:0] OFS_IFLS = 6'h18;
  localparam logic [5:0] OFS_IMSC = 6'h1c;
  localparam logic [5:0] OFS_RIS = 6'h20;
  localparam logic [5:0] OFS_ICR = 6'h24;
  localparam logic [5:0] OFS_ILPR = 6'h28;
  // Line control fields.
  localparam int LCR_WLEN = 0;
  localparam int LCR_STP2 = 2;
  localparam int LCR_PEN = 3;
  localparam int LCR_EPS = 4;
  localparam int LCR_FEN = 5;
  localparam int LCR_BRK = 6;
  // Control fields.
  localparam int CR_EN = 0;
  localparam int CR_TXE = 1;
  localparam int CR_RXE = 2;
  localparam int CR_DTR = 3;
  localparam int CR_RTS = 4;
  localparam int CR_RTSEN = 5;
  localparam int CR_CTSEN = 6;
  // Interrupt source positions.
  localparam int IRQ_RX = 0;
  localparam int IRQ_RT = 1;
  localparam int IRQ_TX = 2;
  localparam int IRQ_MS = 3;
  localparam int IRQ_ERR = 4;
  // Receive entry fields.
  localparam int RXE_FE = 8;
  localparam int RXE_PE = 9;
  localparam int RXE_BE = 10;
  localparam int RXE_OE = 11;
  // Reset values.
  localparam logic [15:0] IBRD_RST = 16'h0000;
  localparam logic [5:0] FBRD_RST = 6'h00;
  localparam logic [6:0] LCR_RST = 7'h00;
  localparam logic [6:0] CR_RST = 7'h06;
  localparam logic [2:0] IFLS_RST = 3'h2;
  // Buffer shape and trigger levels in entries.
  localparam int DEPTH = 16;
  localparam logic [4:0] CAP_ON = 5'h10;
  localparam logic [4:0] CAP_OFF = 5'h01;
  localparam logic [4:0] TRIG_LVL [5] = '{5'h02, 5'h04, 5'h08, 5'h0c, 5'h0e};
  // Timing.
  localparam int REF_HZ = 10_000_000;
  localparam int LP_HZ = 1_843_200;
  localparam int MAX_BAUD = 460_800;
  localparam logic [7:0] LP_DIV_RST = 8'(REF_HZ / LP_HZ);
  localparam logic [9:0] RX_TMO_TICKS = 10'h200;
  localparam logic [3:0] MID_TICK = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hf;

  typedef struct packed {
    logic [5:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ufs_bus_t;

  typedef struct packed {
    logic cts_n;
    logic dcd_n;
    logic dsr_n;
    logic ri_n;
  } ufs_modem_t;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} ufs_state_t;
endpackage

// [ufs_core_checker.sv]
`timescale 1ns/1ps
// Watches the core's ports for register, modem, break, tick and interrupt timing.
module ufs_core_checker (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Register port.
  input wire ufs_pkg::ufs_bus_t bus,
  input wire logic [31:0] rdata,
  // Serial and modem lines.
  input wire logic serial_tx_out,
  input wire ufs_pkg::ufs_modem_t modem,
  input wire logic request_to_send_out_n,
  input wire logic terminal_ready_out_n,
  // Interrupt, DMA and low-power reference.
  input wire logic irq,
  input wire logic tx_dma_req,
  input wire logic rx_dma_req,
  input wire logic lowpower_tick
);
  import ufs_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Control and line control writes that several properties key on.
  sequence cr_wr;
    bus.wr && bus.addr == OFS_CR;
  endsequence
  sequence lcr_wr;
    bus.wr && bus.addr == OFS_LCR;
  endsequence
  chk_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
    else $error("read data present without a read");
  chk_unmapped_zero: assert property (bus.rd && bus.addr > OFS_ILPR |=> rdata == 32'h0)
    else $error("unmapped read gave nonzero data");
  // Status shows the modem levels registered one cycle before the read edge.
  chk_stat_modem: assert property (bus.rd && bus.addr == OFS_STAT
    |=> rdata[11:8] == $past(modem, 2))
    else $error("status read shows wrong modem levels");
  chk_dtr_follow: assert property (cr_wr
    |-> ##2 terminal_ready_out_n == !$past(bus.wdata[CR_DTR], 2))
    else $error("terminal ready output does not follow control");
  chk_rts_follow: assert property (cr_wr ##0 !bus.wdata[CR_RTSEN]
    |-> ##2 request_to_send_out_n == !$past(bus.wdata[CR_RTS], 2))
    else $error("request to send output does not follow control");
  chk_break_low: assert property (lcr_wr ##0 bus.wdata[LCR_BRK] |-> ##2 !serial_tx_out)
    else $error("break did not pull the line low");
  chk_lp_period: assert property (lowpower_tick |=> !lowpower_tick [*4] ##1 lowpower_tick)
    else $error("low-power tick spacing wrong");
  chk_irq_masked: assert property (bus.wr && bus.addr == OFS_IMSC
    && bus.wdata[4:0] == 5'h00 |-> ##2 !irq [*2])
    else $error("interrupt high with all sources masked");
  chk_dma_off: assert property (cr_wr ##0 !bus.wdata[CR_EN]
    |-> ##2 !tx_dma_req && !rx_dma_req)
    else $error("DMA request while disabled");
  chk_idle_rst: assert property ($fell(srst) |-> serial_tx_out && request_to_send_out_n
    && terminal_ready_out_n && !irq)
    else $error("outputs not idle after reset");
endmodule
bind ufs_core ufs_core_checker i_ufs_core_checker (.core_clk(core_clk), .srst(srst), .bus(bus),
  .rdata(rdata), .serial_tx_out(serial_tx_out), .modem(modem),
  .request_to_send_out_n(request_to_send_out_n), .terminal_ready_out_n(terminal_ready_out_n),
  .irq(irq), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req), .lowpower_tick(lowpower_tick));

// [ufs_peer.sv]
`timescale 1ns/1ps
// Far-end serial peer at sixteen clocks per bit: sends frames and samples transmitted ones.
module ufs_peer (
  // Clock.
  input wire logic core_clk,
  // Serial lines.
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'b1;
  // Sends twelve bit times LSB first; the last bit leaves the line idle high.
  task automatic send(input logic [11:0] f);
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk);
      line_out <= f[i];
      repeat (15) @(posedge core_clk);
    end
  endtask
  // Waits a bounded time for a start bit, then samples twelve bits at mid-bit.
  task automatic get(output logic [11:0] f);
    int n;
    n = 0;
    f = 12'hfff;
    while (line_in && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    if (n < 3000) begin
      repeat (8) @(posedge core_clk);
      for (int i = 0; i < 12; i++) begin
        f[i] = line_in;
        if (i < 11) repeat (16) @(posedge core_clk);
      end
    end
  endtask
endmodule

// [tb_uart_fifo_serial_core.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_uart_fifo_serial_core;
  import ufs_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  ufs_bus_t bus = '0;
  ufs_modem_t modem = 4'hf;
  logic [31:0] rdata;
  logic serial_rx_in, serial_tx_out, request_to_send_out_n, terminal_ready_out_n;
  logic irq, tx_dma_req, rx_dma_req, lowpower_tick;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] rv;
  logic [11:0] fr, f2;
  ufs_core i_ufs_core (.core_clk(core_clk), .srst(srst), .bus(bus), .rdata(rdata),
    .serial_rx_in(serial_rx_in), .serial_tx_out(serial_tx_out), .modem(modem),
    .request_to_send_out_n(request_to_send_out_n), .terminal_ready_out_n(terminal_ready_out_n),
    .irq(irq), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req), .lowpower_tick(lowpower_tick));
  ufs_peer i_ufs_peer (.core_clk(core_clk), .line_in(serial_tx_out), .line_out(serial_rx_in));
  // Free-running clock and hang guard.
  initial forever #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  // Frame of 8 data bits, even parity and stop bits, with optional faults.
  function automatic logic [11:0] frm(input logic [7:0] b, input logic pbad, input logic sbad);
    return {1'b1, ~sbad, (^b) ^ pbad, b, 1'b0};
  endfunction
  // One-cycle register write and read.
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Reset values and unmapped reads.
  task automatic t_regs();
    int ticks;
    ticks = 0;
    `CHK(serial_tx_out, 1'b1)
    rd(OFS_CR, rv);
    `CHK(rv, {25'h0, CR_RST})
    rd(OFS_IFLS, rv);
    `CHK(rv, {29'h0, IFLS_RST})
    rd(OFS_IBRD, rv);
    `CHK(rv, {16'h0, IBRD_RST})
    rd(OFS_ILPR, rv);
    `CHK(rv, {24'h0, LP_DIV_RST})
    rd(OFS_STAT, rv);
    `CHK({rv[5], rv[2]}, 2'b11)
    // The fraction register keeps only its six bits.
    wr(OFS_FBRD, 32'hff);
    rd(OFS_FBRD, rv);
    `CHK(rv, 32'h3f)
    wr(OFS_FBRD, 32'h0);
    // Any ten cycles hold exactly two low-power ticks at the reset divisor.
    repeat (10) begin
      @(posedge core_clk);
      ticks += lowpower_tick;
    end
    `CHK(ticks, 10 / LP_DIV_RST)
    rd(6'h2c, rv);
    `CHK(rv, 32'h0)
  endtask
  // Back-to-back transmit frames with two stops and parity, then break.
  task automatic t_tx();
    wr(OFS_IBRD, 32'h1);
    wr(OFS_LCR, 32'h3f);
    wr(OFS_CR, 32'h07);
    fork
      begin
        wr(OFS_DATA, 32'ha5);
        wr(OFS_DATA, 32'h07);
      end
      begin
        i_ufs_peer.get(fr);
        i_ufs_peer.get(f2);
      end
    join
    `CHK(fr, frm(8'ha5, 1'b0, 1'b0))
    `CHK(f2, frm(8'h07, 1'b0, 1'b0))
    `CHK(tx_dma_req, 1'b1)
    wr(OFS_LCR, 32'h7f);
    repeat (3) @(posedge core_clk);
    `CHK(serial_tx_out, 1'b0)
    wr(OFS_LCR, 32'h1b);
  endtask
  // Receive into a one-deep holder: overrun, interrupts and error bits.
  task automatic t_rx();
    i_ufs_peer.send(frm(8'h3c, 1'b0, 1'b0));
    i_ufs_peer.send(frm(8'h55, 1'b0, 1'b0));
    `CHK(rx_dma_req, 1'b1)
    wr(OFS_IMSC, 32'h1 << IRQ_RX);
    repeat (2) @(posedge core_clk);
    `CHK(irq, 1'b1)
    rd(OFS_RIS, rv);
    `CHK({rv[IRQ_ERR], rv[IRQ_RX]}, 2'b11)
    wr(OFS_IMSC, 32'h0);
    rd(OFS_DATA, rv);
    `CHK(rv, 32'h3c)
    i_ufs_peer.send(frm(8'hc3, 1'b0, 1'b0));
    rd(OFS_DATA, rv);
    `CHK(rv, 32'h8c3)
    i_ufs_peer.send(frm(8'h81, 1'b1, 1'b0));
    rd(OFS_DATA, rv);
    `CHK(rv, 32'h281)
    i_ufs_peer.send(frm(8'h81, 1'b0, 1'b1));
    rd(OFS_DATA, rv);
    `CHK(rv, 32'h181)
    i_ufs_peer.send(frm(8'h00, 1'b0, 1'b1));
    // An unread entry with an idle line raises the receive timeout.
    repeat (RX_TMO_TICKS + 10'h010) @(posedge core_clk);
    rd(OFS_RIS, rv);
    `CHK(rv[IRQ_RT], 1'b1)
    rd(OFS_DATA, rv);
    `CHK(rv[RXE_BE], 1'b1)
    rd(OFS_DATA, rv);
    `CHK(rv, 32'h0)
  endtask
  // Modem inputs seen in status, control outputs follow control bits.
  task automatic t_modem();
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      modem <= i ? 4'h5 : 4'ha;
      wr(OFS_CR, i ? 32'h19 : 32'h00);
      rd(OFS_STAT, rv);
      `CHK(rv[11:8], i ? 4'h5 : 4'ha)
      `CHK({request_to_send_out_n, terminal_ready_out_n}, i ? 2'b00 : 2'b11)
    end
  endtask
  // Transmitter holds off while clear-to-send is released; request-to-send stays asserted.
  task automatic t_cts();
    int lows;
    lows = 0;
    @(posedge core_clk);
    modem <= 4'hf;
    wr(OFS_CR, 32'h67);
    wr(OFS_DATA, 32'h5a);
    repeat (300) begin
      @(posedge core_clk);
      lows += !serial_tx_out;
    end
    `CHK(lows, 0)
    `CHK(request_to_send_out_n, 1'b0)
    modem.cts_n <= 1'b0;
    i_ufs_peer.get(fr);
    `CHK(fr, frm(8'h5a, 1'b0, 1'b0))
  endtask
  // Verdict.
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    t_regs();
    t_tx();
    t_rx();
    t_modem();
    t_cts();
    stop_test();
  end
endmodule
